// [core/ufb_cfg.svh]
`ifndef UFB_CFG_SVH
`define UFB_CFG_SVH
// ***************************************************
// register map, byte addresses on the bus
// ***************************************************
`define UFB_A_CONTROL_BUS_PINS 8'h00
`define UFB_A_MODE 8'h04
`define UFB_A_BAUD 8'h08
`define UFB_A_GPIO 8'h0C
`define UFB_A_STAT 8'h10
`define UFB_A_PORT 8'h14
// ***************************************************
// field positions and reset values
// ***************************************************
`define UFB_INV_LSB 20
`define UFB_DRV_LSB 25
`define UFB_DIR_LSB 8
`define UFB_CONTROL_BUS_PINS_RST 30'h0005_1032
`define UFB_BAUD_RST 14'h0010
// ***************************************************
// sizes and timing
// ***************************************************
`define UFB_OBUF_DEPTH 128
`define UFB_IBUF_DEPTH 256
`define UFB_NPIN 5
`define UFB_CLK_MHZ 100
`define UFB_LED_NS 1000
`define UFB_LED_CYC ((`UFB_LED_NS * `UFB_CLK_MHZ + 999) / 1000)
`define UFB_NCO_STEP 32'h7AE1_47AE
`endif

// [core/ufb_pkg.sv]
`include "ufb_cfg.svh"
package ufb_pkg;
   typedef enum logic [1:0] {
      UFB_M_UART = 2'b00,
      UFB_M_ASYNC = 2'b01,
      UFB_M_SYNC = 2'b10
   } ufb_mode_e;
   typedef enum logic [3:0] {
      UFB_F_TX_DRIVE_ENABLE = 4'h0, UFB_F_PWR = 4'h1, UFB_F_TX_INDICATOR_N = 4'h2,
      UFB_F_RX_INDICATOR_N = 4'h3, UFB_F_BOTHLED = 4'h4, UFB_F_SLEEP = 4'h5,
      UFB_F_CK48 = 4'h6, UFB_F_CK24 = 4'h7, UFB_F_CK12 = 4'h8,
      UFB_F_CK6 = 4'h9, UFB_F_GPIO = 4'hA, UFB_F_WRSTB = 4'hB,
      UFB_F_RDSTB = 4'hC
   } ufb_fn_e;
   typedef struct packed {
      logic [29:0] control_bus_pins;
      ufb_mode_e mode;
      logic [7:0] dir;
      logic [13:0] baud;
      logic [3:0] gpo;
      logic [3:0] gpd;
      logic [6:0] o_wr;
      logic [6:0] o_rd;
      logic [7:0] o_cnt;
      logic [7:0] i_wr;
      logic [7:0] i_rd;
      logic [8:0] i_cnt;
      logic ack;
      logic [31:0] rdat;
      logic [13:0] tmr;
      logic [7:0] port_o;
      logic [7:0] port_oen;
      logic wr_n;
      logic rd_n;
      logic [12:0] s1;
      logic [12:0] s2;
      logic [12:0] s3;
      logic [12:0] pf;
      logic [34:0] nco;
      logic [15:0] led_tx;
      logic [15:0] led_rx;
      logic tx_v;
      logic [7:0] tx_d;
      logic [4:0] control_bus_pins_o;
      logic [4:0] control_bus_pins_oen;
   } ufb_state_s;
endpackage : ufb_pkg

// [core/ufb_core.sv]
// ***************************************************
// Summary of operation
// - five control pins, function/invert/drive configured
// - one selected function per pin, defaults preset
// - transmit-enable output while transmitter drives
// - tx, rx and combined activity indicators pulse
// - suspend indicator and power-control output selectable
// - pin selectable as 48/24/12/6 MHz clock
// - four pins usable as GPIO alongside serial
// - bit-bang turns eight lines into parallel port
// - async bit-bang paces bytes by baud timer
// - read and write strobes driven on pins 0 to 3 only
// - sync bit-bang samples pins only per write
// - buffer logic runs on the reference clock
// - clock outputs derived from the reference clock
// - host OUT bytes buffered 128 deep to transmitter
// - received bytes buffered 256 deep for host IN
// - controller moves bytes between buffers and shifters
// - power-control low when configured, high in suspend
// - suspend indicator low throughout suspend
// - clock outputs stop during suspend
// ***************************************************
`timescale 1ns/1ps
module ufb_core (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic out_valid,
   input wire logic [7:0] out_data,
   output logic out_ready,
   output logic in_valid,
   output logic [7:0] in_data,
   input wire logic in_ready,
   output logic ser_tx_valid,
   output logic [7:0] ser_tx_data,
   input wire logic ser_tx_ready,
   input wire logic ser_tx_busy,
   input wire logic ser_rx_valid,
   input wire logic [7:0] ser_rx_data,
   output logic ser_rx_ready,
   input wire logic usb_suspend,
   input wire logic usb_configured,
   input wire logic [7:0] port_in,
   output logic [7:0] port_out,
   output logic [7:0] port_oe_n,
   input wire logic [4:0] control_bus_pins_in,
   output logic [4:0] control_bus_pins_out,
   output logic [4:0] control_bus_pins_oe_n,
   output logic [4:0] control_bus_drive_hi
);
   import ufb_pkg::*;

   ufb_state_s q_r;
   ufb_state_s q_nxt;
   logic [7:0] obuf_mem [0:`UFB_OBUF_DEPTH-1];
   logic [7:0] ibuf_mem [0:`UFB_IBUF_DEPTH-1];
   logic o_push;
   logic o_pop;
   logic i_push;
   logic i_pop;
   logic [7:0] i_wd;
   logic o_full;
   logic i_full;

   function automatic logic [31:0] ufb_merge(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] s);
      for (int b = 0; b < 4; b++) begin
         ufb_merge[8*b +: 8] = s[b] ? d[8*b +: 8] : o[8*b +: 8];
      end
   endfunction : ufb_merge

   // ***************************************************
   // buffer flags and handshakes
   // ***************************************************
   assign o_full = q_r.o_cnt == 8'(`UFB_OBUF_DEPTH);
   assign i_full = q_r.i_cnt == 9'(`UFB_IBUF_DEPTH);
   assign out_ready = !o_full;
   assign in_valid = q_r.i_cnt != 9'd0;
   assign in_data = ibuf_mem[q_r.i_rd];
   assign ser_rx_ready = (q_r.mode == UFB_M_UART) && !i_full;
   assign ser_tx_valid = q_r.tx_v;
   assign ser_tx_data = q_r.tx_d;
   assign wb_ack_o = q_r.ack;
   assign wb_dat_o = q_r.rdat;
   assign port_out = q_r.port_o;
   assign port_oe_n = q_r.port_oen;
   assign control_bus_pins_out = q_r.control_bus_pins_o;
   assign control_bus_pins_oe_n = q_r.control_bus_pins_oen;
   assign control_bus_drive_hi = q_r.control_bus_pins[`UFB_DRV_LSB +: 5];

   // ***************************************************
   // next state
   // ***************************************************
   always_comb begin
      ufb_state_s n;
      logic [31:0] w;
      logic tick;
      logic v;
      logic oen;
      logic [4:0] go;
      logic [4:0] gd;
      n = q_r;
      w = 32'h0000_0000;
      tick = 1'b0;
      v = 1'b0;
      oen = 1'b0;
      go = {1'b0, q_r.gpo};
      gd = {1'b0, q_r.gpd};
      o_push = out_valid && !o_full;
      o_pop = 1'b0;
      i_push = 1'b0;
      i_pop = in_valid && in_ready;
      i_wd = ser_rx_data;
      n.ack = 1'b0;
      n.wr_n = 1'b1;
      n.rd_n = 1'b1;
      // pins: three stages, change taken once stages two and three agree
      n.s1 = {control_bus_pins_in, port_in};
      n.s2 = q_r.s1;
      n.s3 = q_r.s2;
      for (int i = 0; i < 13; i++) begin
         if (q_r.s2[i] == q_r.s3[i]) begin
            n.pf[i] = q_r.s3[i];
         end
      end
      // register bus
      if (wb_cyc_i && wb_stb_i && !q_r.ack) begin
         n.ack = 1'b1;
         case (wb_adr_i)
            `UFB_A_CONTROL_BUS_PINS: w = {2'b00, q_r.control_bus_pins};
            `UFB_A_MODE: w = {16'h0000, q_r.dir, 6'h00, q_r.mode};
            `UFB_A_BAUD: w = {18'h00000, q_r.baud};
            `UFB_A_GPIO: w = {19'h00000, q_r.pf[12:8], q_r.gpd, q_r.gpo};
            `UFB_A_STAT: w = {13'h0000, usb_suspend, usb_configured,
               q_r.i_cnt, q_r.o_cnt};
            `UFB_A_PORT: w = {24'h000000, q_r.pf[7:0]};
            default: w = 32'h0000_0000;
         endcase
         n.rdat = wb_we_i ? 32'h0000_0000 : w;
         if (wb_we_i) begin
            w = ufb_merge(w, wb_dat_i, wb_sel_i);
            case (wb_adr_i)
               `UFB_A_CONTROL_BUS_PINS: n.control_bus_pins = w[29:0];
               `UFB_A_MODE: begin
                  n.mode = ufb_mode_e'(w[1:0]);
                  n.dir = w[`UFB_DIR_LSB +: 8];
               end
               `UFB_A_BAUD: n.baud = w[13:0];
               `UFB_A_GPIO: begin
                  n.gpo = w[3:0];
                  n.gpd = w[7:4];
               end
               default: n.rdat = 32'h0000_0000;
            endcase
         end
      end
      // pace timer shared by both bit-bang modes
      if (q_r.tmr == 14'd0) begin
         n.tmr = q_r.baud;
         tick = 1'b1;
      end else begin
         n.tmr = q_r.tmr - 14'd1;
      end
      // buffer controller
      unique case (q_r.mode)
         UFB_M_UART: begin
            n.port_oen = 8'hFF;
            if (q_r.tx_v && ser_tx_ready) begin
               n.tx_v = 1'b0;
            end
            // refill the transmit register only from a non-empty buffer
            if ((!q_r.tx_v || ser_tx_ready) && q_r.o_cnt != 8'd0) begin
               o_pop = 1'b1;
               n.tx_v = 1'b1;
               n.tx_d = obuf_mem[q_r.o_rd];
            end
            i_push = ser_rx_valid && !i_full;
         end
         UFB_M_ASYNC: begin
            n.port_oen = ~q_r.dir;
            n.tx_v = 1'b0;
            if (tick && q_r.o_cnt != 8'd0) begin
               o_pop = 1'b1;
               n.port_o = obuf_mem[q_r.o_rd];
               n.wr_n = 1'b0;
            end
            // sampling runs on every tick with room in the receive buffer, whether or not a byte went out
            if (tick && !i_full) begin
               i_push = 1'b1;
               i_wd = q_r.pf[7:0];
               n.rd_n = 1'b0;
            end
         end
         UFB_M_SYNC: begin
            n.port_oen = ~q_r.dir;
            n.tx_v = 1'b0;
            // a write waits for room so no sample is ever dropped
            if (tick && q_r.o_cnt != 8'd0 && !i_full) begin
               o_pop = 1'b1;
               n.port_o = obuf_mem[q_r.o_rd];
               n.wr_n = 1'b0;
               i_push = 1'b1;
               i_wd = q_r.pf[7:0];
               n.rd_n = 1'b0;
            end
         end
         default: begin
            n.port_oen = 8'hFF;
            n.tx_v = 1'b0;
         end
      endcase
      if (o_push) begin
         n.o_wr = q_r.o_wr + 7'd1;
      end
      if (o_pop) begin
         n.o_rd = q_r.o_rd + 7'd1;
      end
      if (i_push) begin
         n.i_wr = q_r.i_wr + 8'd1;
      end
      if (i_pop) begin
         n.i_rd = q_r.i_rd + 8'd1;
      end
      n.o_cnt = q_r.o_cnt + 8'(o_push) - 8'(o_pop);
      n.i_cnt = q_r.i_cnt + 9'(i_push) - 9'(i_pop);
      // indicators: stretched so a single byte stays visible
      if (o_push) begin
         n.led_tx = 16'(`UFB_LED_CYC);
      end else if (q_r.led_tx != 16'd0) begin
         n.led_tx = q_r.led_tx - 16'd1;
      end
      if (i_pop) begin
         n.led_rx = 16'(`UFB_LED_CYC);
      end else if (q_r.led_rx != 16'd0) begin
         n.led_rx = q_r.led_rx - 16'd1;
      end
      // one accumulator; bits 31..34 give 48, 24, 12 and 6 MHz on
      // average, with up to one reference period of jitter
      n.nco = q_r.nco + {3'b000, `UFB_NCO_STEP};
      // control pins
      for (int p = 0; p < `UFB_NPIN; p++) begin
         v = 1'b0;
         oen = 1'b0;
         case (q_r.control_bus_pins[4*p +: 4])
            UFB_F_TX_DRIVE_ENABLE: v = ser_tx_busy | q_r.tx_v;
            UFB_F_PWR: v = !(usb_configured && !usb_suspend);
            UFB_F_TX_INDICATOR_N: v = q_r.led_tx == 16'd0;
            UFB_F_RX_INDICATOR_N: v = q_r.led_rx == 16'd0;
            UFB_F_BOTHLED: begin
               v = (q_r.led_tx == 16'd0) && (q_r.led_rx == 16'd0);
            end
            UFB_F_SLEEP: v = !usb_suspend;
            UFB_F_CK48: v = q_r.nco[31] && !usb_suspend;
            UFB_F_CK24: v = q_r.nco[32] && !usb_suspend;
            UFB_F_CK12: v = q_r.nco[33] && !usb_suspend;
            UFB_F_CK6: v = q_r.nco[34] && !usb_suspend;
            UFB_F_GPIO: begin
               v = go[p];
               oen = !gd[p];
            end
            UFB_F_WRSTB: begin
               v = q_r.wr_n;
               oen = p == 4;
            end
            UFB_F_RDSTB: begin
               v = q_r.rd_n;
               oen = p == 4;
            end
            default: oen = 1'b1;
         endcase
         n.control_bus_pins_o[p] = v ^ q_r.control_bus_pins[`UFB_INV_LSB + p];
         n.control_bus_pins_oen[p] = oen;
      end
      q_nxt = n;
   end

   // ***************************************************
   // state and buffer storage
   // ***************************************************
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         q_r <= '0;
         q_r.control_bus_pins <= `UFB_CONTROL_BUS_PINS_RST;
         q_r.baud <= `UFB_BAUD_RST;
         q_r.wr_n <= 1'b1;
         q_r.rd_n <= 1'b1;
         q_r.port_oen <= 8'hFF;
         q_r.control_bus_pins_oen <= 5'h1F;
         q_r.control_bus_pins_o <= 5'h1F;
      end else begin
         q_r <= q_nxt;
      end
   end

   // storage has no reset; the counts say what is valid
   always_ff @(posedge ref_clk) begin
      if (o_push) begin
         obuf_mem[q_r.o_wr] <= out_data;
      end
      if (i_push) begin
         ibuf_mem[q_r.i_wr] <= i_wd;
      end
   end

   // ***************************************************
   // assertions
   // ***************************************************
   default clocking ufb_cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   sequence ufb_led_low;
      ##2 !control_bus_pins_out[0];
   endsequence
   sequence ufb_quiet3;
      ##1 q_r.wr_n [*3];
   endsequence

   buf_bound_a: assert property (
      q_r.o_cnt <= 8'd128 && q_r.i_cnt <= 9'd256)
      else $error("buffer count beyond depth");
   rx_refuse_a: assert property (
      q_r.i_cnt == 9'd256 |-> !ser_rx_ready && !i_push)
      else $error("full receive side accepted a byte");
   tx_empty_a: assert property (
      q_r.mode == UFB_M_UART && q_r.o_cnt == 8'd0 && !q_r.tx_v
      |=> !q_r.tx_v)
      else $error("transmitter fed from empty buffer");
   out_full_a: assert property (
      q_r.o_cnt == 8'd128 |-> !out_ready ##1 q_r.o_cnt <= 8'd128)
      else $error("full host buffer still ready");
   clk_stop_a: assert property (
      usb_suspend && q_r.control_bus_pins[11:8] == UFB_F_CK48 && !q_r.control_bus_pins[22]
      && !wb_cyc_i |=> !control_bus_pins_out[2])
      else $error("clock output toggles in suspend");
   sleep_low_a: assert property (
      usb_suspend && q_r.control_bus_pins[19:16] == UFB_F_SLEEP && !q_r.control_bus_pins[24]
      && !wb_cyc_i |=> !control_bus_pins_out[4])
      else $error("suspend indicator not low");
   pwr_ctl_a: assert property (
      usb_configured && !usb_suspend && q_r.control_bus_pins[15:12] == UFB_F_PWR
      && !q_r.control_bus_pins[23] && !wb_cyc_i |=> !control_bus_pins_out[3])
      else $error("power control not low when configured");
   tx_led_a: assert property (
      o_push && q_r.control_bus_pins[3:0] == UFB_F_TX_INDICATOR_N && !q_r.control_bus_pins[20]
      && !wb_cyc_i ##1 !wb_cyc_i |-> ufb_led_low)
      else $error("transmit indicator did not pulse");
   sync_pair_a: assert property (
      q_r.mode == UFB_M_SYNC && $fell(q_r.wr_n) |-> !q_r.rd_n)
      else $error("sync write without matching sample");
   async_pace_a: assert property (
      q_r.mode == UFB_M_ASYNC && !q_r.wr_n && q_r.baud >= 14'd3
      && !wb_cyc_i |-> ufb_quiet3)
      else $error("bit-bang bytes paced too fast");
endmodule : ufb_core

// [tb/ufb_ser_model.sv]
`timescale 1ns/1ps
// ****
// serial far side: loops each sent byte back after a shift time
// ****
module ufb_ser_model (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic stall,
   input wire logic ser_tx_valid,
   input wire logic [7:0] ser_tx_data,
   output logic ser_tx_ready,
   output logic ser_tx_busy,
   output logic ser_rx_valid,
   output logic [7:0] ser_rx_data,
   input wire logic ser_rx_ready
);
   logic [3:0] bit_cnt;
   logic [7:0] shreg;
   // stall holds the transmitter off so the buffer can be filled
   assign ser_tx_ready = !stall && !ser_tx_busy && !ser_rx_valid;
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         ser_tx_busy <= 1'b0;
         ser_rx_valid <= 1'b0;
         ser_rx_data <= 8'h00;
         bit_cnt <= 4'h0;
      end else begin
         if (ser_rx_valid && ser_rx_ready) begin
            ser_rx_valid <= 1'b0;
         end
         // no byte offered: line keeps changing, never the last value
         if (!ser_rx_valid) begin
            ser_rx_data <= ~ser_rx_data;
         end
         if (ser_tx_valid && ser_tx_ready) begin
            ser_tx_busy <= 1'b1;
            shreg <= ser_tx_data;
            bit_cnt <= 4'h9;
         end else if (ser_tx_busy) begin
            bit_cnt <= bit_cnt - 4'h1;
            if (bit_cnt == 4'h1) begin
               ser_tx_busy <= 1'b0;
               ser_rx_valid <= 1'b1;
               ser_rx_data <= shreg;
            end
         end
      end
   end
endmodule : ufb_ser_model

// [tb/ufb_core_tb.sv]
`timescale 1ns/1ps
module ufb_core_tb;
   import ufb_pkg::*;
   logic ref_clk, sys_rst, cyc, stb, we, out_valid, in_ready, stall;
   logic usb_suspend, usb_configured, ack, out_ready, in_valid;
   logic txv, txr, txb, rxv, rxr;
   logic [7:0] adr, out_data, in_data, port_out, port_oe_n, ext, fill;
   logic [7:0] txd, rxd;
   logic [31:0] dat_w, dat_r, seed;
   logic [3:0] sel;
   logic [4:0] cb_out, cb_oe_n, cb_hi, cb_prev;
   logic [31:0] rd_q[$];
   logic [7:0] in_q[$];
   int error_cnt, check_count;
   int cnt[5], snap[5];
   // pins resolve from enables; released control pins are pulled up
   wire [7:0] port_w = (~port_oe_n & port_out) | (port_oe_n & ext);
   wire [4:0] cb_w = (~cb_oe_n & cb_out) | cb_oe_n;
   ufb_core i_ufb_core (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
      .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
      .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
      .ser_tx_valid(txv), .ser_tx_data(txd), .ser_tx_ready(txr),
      .ser_tx_busy(txb), .ser_rx_valid(rxv), .ser_rx_data(rxd),
      .ser_rx_ready(rxr), .usb_suspend(usb_suspend),
      .usb_configured(usb_configured), .port_in(port_w),
      .port_out(port_out), .port_oe_n(port_oe_n),
      .control_bus_pins_in(cb_w), .control_bus_pins_out(cb_out),
      .control_bus_pins_oe_n(cb_oe_n), .control_bus_drive_hi(cb_hi));
   ufb_ser_model i_ufb_ser_model (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .stall(stall), .ser_tx_valid(txv), .ser_tx_data(txd),
      .ser_tx_ready(txr), .ser_tx_busy(txb), .ser_rx_valid(rxv),
      .ser_rx_data(rxd), .ser_rx_ready(rxr));
   // ****
   // tasks
   // ****
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] e);
      @(posedge ref_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      if (!w) rd_q.push_back(e);
      do @(posedge ref_clk); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   // valid stays up between bytes; the caller lowers it at the end
   task automatic send(input logic [7:0] b);
      out_data <= b;
      out_valid <= 1'b1;
      do @(posedge ref_clk); while (out_ready !== 1'b1);
   endtask : send
   task automatic wait_pin(input int i, input logic v);
      int n;
      n = 0;
      while (cb_out[i] !== v && n < 60) begin
         @(posedge ref_clk);
         n++;
      end
      chk("control_bus_pins_out", v, cb_out[i]);
   endtask : wait_pin
   task automatic drain();
      int n;
      logic [31:0] r;
      n = 0;
      while ((in_valid !== 1'b0 || in_q.size() > 0) && n < 9000) begin
         @(posedge ref_clk);
         r = xs();
         in_ready <= r[0];
         n++;
      end
      @(posedge ref_clk);
      in_ready <= 1'b0;
      chk("drain_left", 32'h0, in_q.size());
   endtask : drain
   task automatic close_out();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out
   // ****
   // monitors, clock, watchdog, sequence
   // ****
   always @(posedge ref_clk) begin
      if (ack === 1'b1 && we === 1'b0) chk("wb_dat_o", rd_q.pop_front(), dat_r);
      if (in_valid === 1'b1 && in_ready === 1'b1) begin
         chk("in_data", in_q.size() ? in_q.pop_front() : fill, in_data);
      end
      for (int i = 0; i < 5; i++) cnt[i] += (cb_out[i] && !cb_prev[i]);
      cb_prev = cb_out;
   end
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (40000) @(posedge ref_clk);
      error_cnt++;
      close_out();
   end
   initial begin : main
      logic [31:0] r;
      logic [7:0] prev;
      {sys_rst, sel, seed} = {1'b1, 4'hF, 32'h0000_000D};
      {cyc, stb, we, adr, dat_w, out_valid, out_data} = '0;
      {in_ready, stall, usb_suspend, usb_configured, fill} = '0;
      r = xs();
      ext = r[7:0];
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk("power_control_n", 1'b1, cb_out[3]);
      chk("sleep_n", 1'b1, cb_out[4]);
      chk("tx_indicator_n", 1'b1, cb_out[0]);
      wb(1'b0, `UFB_A_CONTROL_BUS_PINS, 32'h0, 32'h0005_1032);
      wb(1'b0, `UFB_A_BAUD, 32'h0, 32'h0000_0010);
      wb(1'b1, 8'h20, 32'hFFFF_FFFF, 32'h0);
      wb(1'b0, 8'h20, 32'h0, 32'h0);
      usb_configured <= 1'b1;
      usb_suspend <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk("power_control_n", 1'b1, cb_out[3]);
      chk("sleep_n", 1'b0, cb_out[4]);
      usb_suspend <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk("power_control_n", 1'b0, cb_out[3]);
      wb(1'b0, `UFB_A_STAT, 32'h0, 32'h0002_0000);
      // transmitter stalled: 128 in buffer plus one in the tx register
      stall <= 1'b1;
      for (int k = 0; k < 129; k++) begin
         r = xs();
         in_q.push_back(r[7:0]);
         send(r[7:0]);
      end
      out_valid <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk("out_ready", 1'b0, out_ready);
      chk("tx_drive_enable", 1'b1, cb_out[2]);
      chk("tx_indicator_n", 1'b0, cb_out[0]);
      wb(1'b0, `UFB_A_STAT, 32'h0, 32'h0002_0080);
      stall <= 1'b0;
      drain();
      repeat (2) @(posedge ref_clk);
      chk("rx_indicator_n", 1'b0, cb_out[1]);
      wb(1'b1, `UFB_A_CONTROL_BUS_PINS, 32'h0427_46A8, 32'h0);
      wb(1'b0, `UFB_A_CONTROL_BUS_PINS, 32'h0, 32'h0427_46A8);
      wb(1'b1, `UFB_A_GPIO, 32'h0000_0022, 32'h0);
      repeat (3) @(posedge ref_clk);
      chk("gpio_inverted", 1'b0, cb_out[1]);
      chk("gpio_oe_n", 1'b0, cb_oe_n[1]);
      chk("control_bus_drive_hi", 5'b00010, cb_hi);
      snap = cnt;
      repeat (200) @(posedge ref_clk);
      chk("clk_out_12m", 1'b1, (cnt[0] - snap[0]) inside {[23:25]});
      chk("clk_out_48m", 1'b1, (cnt[2] - snap[2]) inside {[95:97]});
      chk("clk_out_24m", 1'b1, (cnt[4] - snap[4]) inside {[47:49]});
      usb_suspend <= 1'b1;
      repeat (3) @(posedge ref_clk);
      snap = cnt;
      repeat (100) @(posedge ref_clk);
      chk("clk_stop", 32'h0, cnt[0] + cnt[2] + cnt[4] - snap[0] - snap[2]
          - snap[4]);
      wb(1'b0, `UFB_A_GPIO, 32'h0, 32'h0000_0822);
      usb_suspend <= 1'b0;
      wb(1'b1, `UFB_A_CONTROL_BUS_PINS, 32'h0000_00CB, 32'h0);
      in_ready <= 1'b1;
      wb(1'b1, `UFB_A_MODE, 32'h0000_0F02, 32'h0);
      // let the newly driven low nibble pass the pin synchroniser
      repeat (4) @(posedge ref_clk);
      prev = 8'h00;
      for (int k = 0; k < 4; k++) begin
         r = xs();
         in_q.push_back({ext[7:4], prev[3:0]});
         prev = r[7:0];
         send(prev);
      end
      out_valid <= 1'b0;
      wait_pin(0, 1'b0);
      drain();
      chk("port_out", prev, port_out);
      chk("port_oe_n", 8'hF0, port_oe_n);
      wb(1'b1, `UFB_A_MODE, 32'h0000_0003, 32'h0);
      repeat (4) @(posedge ref_clk);
      wb(1'b1, `UFB_A_MODE, 32'h0000_0001, 32'h0);
      r = xs();
      send(r[7:0]);
      out_valid <= 1'b0;
      wait_pin(0, 1'b0);
      repeat (2) @(posedge ref_clk);
      chk("port_out", r[7:0], port_out);
      wait_pin(1, 1'b0);
      repeat (4500) @(posedge ref_clk);
      wb(1'b0, `UFB_A_STAT, 32'h0, 32'h0003_0000);
      wb(1'b1, `UFB_A_MODE, 32'h0000_0003, 32'h0);
      fill = ext;
      drain();
      close_out();
   end
endmodule : ufb_core_tb
